// File: hw/flash_cmd_pkg.sv
// flash_cmd_pkg: command codes, field positions, reset values and mode types
// shared by the flash bus command front end; assumes a 16-bit data bus.
package flash_cmd_pkg;
	// bus widths
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	// write-buffer depth, words
	localparam int BUF_WORDS = 32;
	localparam int BUF_IDX_W = 5;

	// command codes carried on the low data byte
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_READ_IDENT = 8'h90;
	localparam logic [7:0] CMD_READ_QUERY = 8'h98;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_PROGRAM_A = 8'h40;
	localparam logic [7:0] CMD_PROGRAM_B = 8'h10;
	localparam logic [7:0] CMD_BUF_WRITE = 8'he8;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_CONFIG = 8'h60;
	localparam logic [7:0] CMD_CONFIG_SET = 8'h03;
	localparam logic [7:0] CMD_PIN_CONFIG = 8'hb8;
	localparam logic [7:0] CMD_PROT_PROGRAM = 8'hc0;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'hd0;

	// status register
	localparam logic [7:0] STATUS_RESET = 8'h80;
	localparam int ST_READY_BIT = 7;
	localparam int ST_SUSP_BIT = 6;
	localparam int ST_ERASE_ERR_BIT = 5;
	localparam int ST_PROG_ERR_BIT = 4;

	// read configuration setting
	localparam logic [15:0] READ_CFG_RESET = 16'hffc7;
	localparam int READ_CFG_MODE_BIT = 15;
	localparam int CFG_ADDR_W = 16;

	// progress pin configuration: 0 is a busy level, others pulse on done
	localparam logic [7:0] PIN_CFG_RESET = 8'h00;
	localparam logic [7:0] PIN_CFG_LEVEL = 8'h00;

	// read modes of the output path
	typedef enum logic [1:0] {
		rd_array,
		rd_ident,
		rd_status,
		rd_query
	} read_mode_type;

	// operations handed to the array engine
	typedef enum logic [1:0] {
		op_word,
		op_buffer,
		op_erase,
		op_protect
	} op_kind_type;
endpackage

// File: hw/flash_bus_command_interface.sv
// flash_bus_command_interface: bus-pin front end and command decoder of a
// nor flash; drives an array engine that runs program and erase itself.
// assumes all pins are already synchronous to clk; the engine reports busy,
// done and fail, and reads the write buffer through buf_rd_idx.
//
// Overview of operation
// - writes are asynchronous; burst clock never used
// - latch address/data at first rising strobe
// - output enable inactive floats data outputs
// - deselect floats outputs; no extra read latency
// - deselect never stops running program or erase
// - reset gives read array, status 0x80
// - reset pin low floats all output drivers
// - reset pin aborts program/erase, back to array
// - operation start switches reads to status
// - four read modes, changed by command or reset pin
// - code 0xff between sequences selects array reads
// - 0x90 ident, 0x98 query, 0x70 status, 0x50 clears
// - program: 0x40 or 0x10, then address and data
// - buffered: 0xe8, count, words, then 0xd0
// - erase: 0x20 in block, then 0xd0
// - 0x60,0x03 sets config from low address
// - 0xb8 then low data byte configures progress pin
// - 0xc0 then word programs protection area
// - page reads default; burst needs config enabled
// - output enable beats write strobe
// - config bit 15: 1 page, 0 burst
`timescale 1ns/100ps
`default_nettype none

module flash_bus_command_interface (
	input wire logic clk,
	input wire logic rst_n,
	// host bus pins
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_enable_n,
	input wire logic device_reset_n,
	input wire logic [flash_cmd_pkg::ADDR_W-1:0] address,
	input wire logic [flash_cmd_pkg::DATA_W-1:0] data_in,
	output logic [flash_cmd_pkg::DATA_W-1:0] data_out,
	output logic data_oe,
	output logic progress_pin,
	// read sources behind the output mux
	output logic [flash_cmd_pkg::ADDR_W-1:0] read_addr,
	input wire logic [flash_cmd_pkg::DATA_W-1:0] array_rd_data,
	input wire logic [flash_cmd_pkg::DATA_W-1:0] ident_rd_data,
	input wire logic [flash_cmd_pkg::DATA_W-1:0] query_rd_data,
	// array engine
	output logic eng_start,
	output logic [1:0] eng_kind,
	output logic [flash_cmd_pkg::ADDR_W-1:0] eng_addr,
	output logic [flash_cmd_pkg::DATA_W-1:0] eng_data,
	output logic [flash_cmd_pkg::BUF_IDX_W:0] eng_count,
	output logic eng_suspend,
	output logic eng_resume,
	output logic eng_abort,
	input wire logic eng_busy,
	input wire logic eng_done,
	input wire logic eng_fail,
	input wire logic [flash_cmd_pkg::BUF_IDX_W-1:0] buf_rd_idx,
	output logic [flash_cmd_pkg::ADDR_W-1:0] buf_rd_addr,
	output logic [flash_cmd_pkg::DATA_W-1:0] buf_rd_data,
	// read configuration as seen by the read path
	output logic [15:0] read_config,
	output logic burst_enable
);

	// command sequencer states
	typedef enum logic [3:0] {
		seq_idle,
		seq_prog,
		seq_buf_count,
		seq_buf_data,
		seq_buf_confirm,
		seq_erase,
		seq_config,
		seq_pin,
		seq_protect
	} seq_type;

	// true when the low byte carries the given code
	function automatic logic is_cmd(input logic [15:0] d, input logic [7:0] c);
		is_cmd = (d[7:0] == c);
	endfunction

	// pin decode
	wire logic pin_reset = !device_reset_n;
	// output enable overrides a simultaneous strobe
	wire logic wr_active = !pin_reset && !chip_select_n && !write_strobe_n && output_enable_n;
	wire logic rd_active = !pin_reset && !chip_select_n && !output_enable_n;

	// write capture
	logic wr_active_r;
	logic [flash_cmd_pkg::ADDR_W-1:0] lat_addr_r;
	logic [flash_cmd_pkg::DATA_W-1:0] lat_data_r;
	// a write ends on the first rising of strobe or select
	wire logic commit = wr_active_r && !wr_active && !pin_reset;
	wire logic [7:0] code = lat_data_r[7:0];

	// control state
	seq_type seq_r, seq_nxt;
	flash_cmd_pkg::read_mode_type mode_r, mode_nxt;
	logic [6:0] status_r, status_nxt; // bit 7 is live ready
	logic [15:0] cfg_r, cfg_nxt;
	logic [7:0] pin_cfg_r, pin_cfg_nxt;
	logic suspended_r, suspended_nxt;
	logic [flash_cmd_pkg::BUF_IDX_W:0] buf_target_r, buf_target_nxt;
	logic [flash_cmd_pkg::BUF_IDX_W:0] buf_fill_r, buf_fill_nxt;
	logic [flash_cmd_pkg::ADDR_W-1:0] blk_addr_r, blk_addr_nxt;
	logic start_nxt, suspend_nxt, resume_nxt;
	flash_cmd_pkg::op_kind_type kind_r, kind_nxt;
	logic [flash_cmd_pkg::ADDR_W-1:0] op_addr_nxt;
	logic [flash_cmd_pkg::DATA_W-1:0] op_data_nxt;

	// write buffer memory, filled by the buffered sequence
	logic [flash_cmd_pkg::DATA_W-1:0] buf_data_mem [flash_cmd_pkg::BUF_WORDS];
	logic [flash_cmd_pkg::ADDR_W-1:0] buf_addr_mem [flash_cmd_pkg::BUF_WORDS];
	wire logic buf_write = commit && (seq_r == seq_buf_data);
	wire logic [flash_cmd_pkg::BUF_IDX_W-1:0] buf_wr_idx = buf_fill_r[flash_cmd_pkg::BUF_IDX_W-1:0];

	// status byte as read back; ready follows the engine live
	wire logic [7:0] status_byte = {!eng_busy, status_r};
	wire logic cfg_addr_ok = (lat_addr_r[flash_cmd_pkg::ADDR_W-1:flash_cmd_pkg::CFG_ADDR_W] == '0);
	// new operations are only taken while the engine rests
	wire logic eng_idle = !eng_busy && !suspended_r;

	// command decoder; the clock only samples pins, strobes carry the cycle
	always_comb begin
		seq_nxt = seq_r;
		mode_nxt = mode_r;
		status_nxt = status_r;
		cfg_nxt = cfg_r;
		pin_cfg_nxt = pin_cfg_r;
		suspended_nxt = suspended_r;
		buf_target_nxt = buf_target_r;
		buf_fill_nxt = buf_fill_r;
		blk_addr_nxt = blk_addr_r;
		start_nxt = 1'b0;
		suspend_nxt = 1'b0;
		resume_nxt = 1'b0;
		kind_nxt = kind_r;
		op_addr_nxt = eng_addr;
		op_data_nxt = eng_data;
		if (commit) begin
			case (seq_r)
				seq_idle: begin
					if (code == flash_cmd_pkg::CMD_READ_ARRAY) begin
						mode_nxt = flash_cmd_pkg::rd_array;
					end else if (code == flash_cmd_pkg::CMD_READ_IDENT) begin
						mode_nxt = flash_cmd_pkg::rd_ident;
					end else if (code == flash_cmd_pkg::CMD_READ_QUERY) begin
						mode_nxt = flash_cmd_pkg::rd_query;
					end else if (code == flash_cmd_pkg::CMD_READ_STATUS) begin
						mode_nxt = flash_cmd_pkg::rd_status;
					end else if (code == flash_cmd_pkg::CMD_CLEAR_STATUS) begin
						status_nxt[5:0] = 6'h00;
					end else if (code == flash_cmd_pkg::CMD_SUSPEND) begin
						// only a running operation can pause
						if (eng_busy) begin
							suspend_nxt = 1'b1;
							suspended_nxt = 1'b1;
							mode_nxt = flash_cmd_pkg::rd_status;
						end
					end else if (code == flash_cmd_pkg::CMD_RESUME && suspended_r) begin
						resume_nxt = 1'b1;
						suspended_nxt = 1'b0;
						mode_nxt = flash_cmd_pkg::rd_status;
					end else if (eng_idle) begin
						// setup codes; ignored while an operation holds the engine
						if (code == flash_cmd_pkg::CMD_PROGRAM_A || code == flash_cmd_pkg::CMD_PROGRAM_B) begin
							seq_nxt = seq_prog;
						end else if (code == flash_cmd_pkg::CMD_BUF_WRITE) begin
							seq_nxt = seq_buf_count;
							blk_addr_nxt = lat_addr_r;
							mode_nxt = flash_cmd_pkg::rd_status;
						end else if (code == flash_cmd_pkg::CMD_ERASE) begin
							seq_nxt = seq_erase;
							blk_addr_nxt = lat_addr_r;
						end else if (code == flash_cmd_pkg::CMD_CONFIG) begin
							seq_nxt = seq_config;
						end else if (code == flash_cmd_pkg::CMD_PIN_CONFIG) begin
							seq_nxt = seq_pin;
						end else if (code == flash_cmd_pkg::CMD_PROT_PROGRAM) begin
							seq_nxt = seq_protect;
						end
					end
				end
				seq_prog: begin
					// second cycle: target address and word
					start_nxt = 1'b1;
					kind_nxt = flash_cmd_pkg::op_word;
					op_addr_nxt = lat_addr_r;
					op_data_nxt = lat_data_r;
					mode_nxt = flash_cmd_pkg::rd_status;
					seq_nxt = seq_idle;
				end
				seq_buf_count: begin
					// a count beyond the buffer is a sequence error
					if (lat_data_r > 16'(flash_cmd_pkg::BUF_WORDS) || lat_data_r == 16'h0000) begin
						status_nxt[flash_cmd_pkg::ST_ERASE_ERR_BIT] = 1'b1;
						status_nxt[flash_cmd_pkg::ST_PROG_ERR_BIT] = 1'b1;
						seq_nxt = seq_idle;
					end else begin
						buf_target_nxt = lat_data_r[flash_cmd_pkg::BUF_IDX_W:0];
						buf_fill_nxt = '0;
						seq_nxt = seq_buf_data;
					end
				end
				seq_buf_data: begin
					buf_fill_nxt = buf_fill_r + 1'b1;
					if (buf_fill_r + 1'b1 == buf_target_r) begin
						seq_nxt = seq_buf_confirm;
					end
				end
				seq_buf_confirm, seq_erase: begin
					seq_nxt = seq_idle;
					mode_nxt = flash_cmd_pkg::rd_status;
					if (is_cmd(lat_data_r, flash_cmd_pkg::CMD_CONFIRM)) begin
						start_nxt = 1'b1;
						kind_nxt = (seq_r == seq_erase) ? flash_cmd_pkg::op_erase : flash_cmd_pkg::op_buffer;
						op_addr_nxt = blk_addr_r;
						op_data_nxt = lat_data_r;
					end else begin
						// anything else aborts the sequence and flags it
						status_nxt[flash_cmd_pkg::ST_ERASE_ERR_BIT] = 1'b1;
						status_nxt[flash_cmd_pkg::ST_PROG_ERR_BIT] = 1'b1;
					end
				end
				seq_config: begin
					// setting on low address lines, upper lines must be zero
					if (is_cmd(lat_data_r, flash_cmd_pkg::CMD_CONFIG_SET) && cfg_addr_ok) begin
						cfg_nxt = lat_addr_r[flash_cmd_pkg::CFG_ADDR_W-1:0];
					end
					seq_nxt = seq_idle;
				end
				seq_pin: begin
					pin_cfg_nxt = code;
					seq_nxt = seq_idle;
				end
				seq_protect: begin
					start_nxt = 1'b1;
					kind_nxt = flash_cmd_pkg::op_protect;
					op_addr_nxt = lat_addr_r;
					op_data_nxt = lat_data_r;
					mode_nxt = flash_cmd_pkg::rd_status;
					seq_nxt = seq_idle;
				end
				default: seq_nxt = seq_idle;
			endcase
		end
		// engine failure sets a flag; it wins over a clear in the same cycle
		if (eng_fail) begin
			if (kind_r == flash_cmd_pkg::op_erase) begin
				status_nxt[flash_cmd_pkg::ST_ERASE_ERR_BIT] = 1'b1;
			end else begin
				status_nxt[flash_cmd_pkg::ST_PROG_ERR_BIT] = 1'b1;
			end
		end
		status_nxt[flash_cmd_pkg::ST_SUSP_BIT] = suspended_nxt;
		// reset pin: abort, back to array reads, status to reset value
		if (pin_reset) begin
			seq_nxt = seq_idle;
			mode_nxt = flash_cmd_pkg::rd_array;
			status_nxt = flash_cmd_pkg::STATUS_RESET[6:0];
			cfg_nxt = flash_cmd_pkg::READ_CFG_RESET;
			suspended_nxt = 1'b0;
			start_nxt = 1'b0;
			suspend_nxt = 1'b0;
			resume_nxt = 1'b0;
		end
	end

	// output data select for the current read mode
	logic [flash_cmd_pkg::DATA_W-1:0] rd_mux;
	assign rd_mux = (mode_r == flash_cmd_pkg::rd_ident) ? ident_rd_data :
		(mode_r == flash_cmd_pkg::rd_query) ? query_rd_data :
		(mode_r == flash_cmd_pkg::rd_status) ? {8'h00, status_byte} : array_rd_data;

	// progress pin: busy level or a done pulse
	wire logic pin_nxt = (pin_cfg_r == flash_cmd_pkg::PIN_CFG_LEVEL) ? eng_busy : eng_done;

	// pin capture; address and data follow the bus while a write is active
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_active_r <= 1'b0;
			lat_addr_r <= '0;
			lat_data_r <= '0;
		end else begin
			wr_active_r <= wr_active;
			if (wr_active) begin
				lat_addr_r <= address;
				lat_data_r <= data_in;
			end
		end
	end

	// sequencer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_r <= seq_idle;
			mode_r <= flash_cmd_pkg::rd_array;
			status_r <= flash_cmd_pkg::STATUS_RESET[6:0];
			cfg_r <= flash_cmd_pkg::READ_CFG_RESET;
			pin_cfg_r <= flash_cmd_pkg::PIN_CFG_RESET;
			suspended_r <= 1'b0;
			buf_target_r <= '0;
			buf_fill_r <= '0;
			blk_addr_r <= '0;
			kind_r <= flash_cmd_pkg::op_word;
		end else begin
			seq_r <= seq_nxt;
			mode_r <= mode_nxt;
			status_r <= status_nxt;
			cfg_r <= cfg_nxt;
			pin_cfg_r <= pin_cfg_nxt;
			suspended_r <= suspended_nxt;
			buf_target_r <= buf_target_nxt;
			buf_fill_r <= buf_fill_nxt;
			blk_addr_r <= blk_addr_nxt;
			kind_r <= kind_nxt;
		end
	end

	// engine handshake outputs; deselect has no effect here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eng_start <= 1'b0;
			eng_kind <= 2'h0;
			eng_addr <= '0;
			eng_data <= '0;
			eng_count <= '0;
			eng_suspend <= 1'b0;
			eng_resume <= 1'b0;
			eng_abort <= 1'b0;
		end else begin
			eng_start <= start_nxt;
			eng_kind <= kind_nxt;
			eng_addr <= op_addr_nxt;
			eng_data <= op_data_nxt;
			eng_count <= buf_target_r;
			eng_suspend <= suspend_nxt;
			eng_resume <= resume_nxt;
			eng_abort <= pin_reset;
		end
	end

	// buffer storage; no reset needed, contents only valid once filled
	always_ff @(posedge clk) begin
		if (buf_write) begin
			buf_data_mem[buf_wr_idx] <= lat_data_r;
			buf_addr_mem[buf_wr_idx] <= lat_addr_r;
		end
		buf_rd_data <= buf_data_mem[buf_rd_idx];
		buf_rd_addr <= buf_addr_mem[buf_rd_idx];
	end

	// output path: one-cycle pipeline regardless of standby history
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= '0;
			data_oe <= 1'b0;
			read_addr <= '0;
			progress_pin <= 1'b0;
			read_config <= flash_cmd_pkg::READ_CFG_RESET;
			burst_enable <= 1'b0;
		end else begin
			data_out <= rd_mux;
			data_oe <= rd_active;
			read_addr <= address;
			progress_pin <= pin_reset ? 1'b0 : pin_nxt;
			read_config <= cfg_r;
			// burst only when configured and reading the array
			burst_enable <= !cfg_r[flash_cmd_pkg::READ_CFG_MODE_BIT] && (mode_r == flash_cmd_pkg::rd_array);
		end
	end

endmodule

`default_nettype wire

// File: testbench/flash_bus_command_interface_props.sv
// flash_bus_command_interface_props: port-level timing checks of the command front end
// assumes one clock domain; bound to every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module flash_bus_command_interface_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic chip_select_n,
	input wire logic output_enable_n,
	input wire logic device_reset_n,
	input wire logic data_oe,
	input wire logic progress_pin,
	input wire logic eng_start,
	input wire logic eng_abort,
	input wire logic [15:0] read_config,
	input wire logic burst_enable
);
	// single domain, so one clocking and one disable serve all
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_oe_float: assert property ($past(output_enable_n) |-> !data_oe)
		else $error("data driven while output enable was off");
	a_cs_float: assert property (chip_select_n [*2] |-> !data_oe)
		else $error("data driven while deselected");
	a_read_answer: assert property (!chip_select_n && !output_enable_n && device_reset_n |=> data_oe)
		else $error("read not answered in one cycle");
	a_rst_float: assert property (!device_reset_n |=> !data_oe && !progress_pin)
		else $error("outputs driven during device reset");
	// the setting passes two registers on its way to the port
	a_cfg_default: assert property (!device_reset_n |-> ##2 (read_config == 16'hffc7 && !burst_enable))
		else $error("read setting not back to default");
	a_abort_follows: assert property ($fell(device_reset_n) |=> eng_abort)
		else $error("abort missing after device reset");
	a_no_start: assert property (!device_reset_n |=> !eng_start)
		else $error("operation started during device reset");
	a_start_pulse: assert property (eng_start |=> !eng_start)
		else $error("start wider than one cycle");
	a_burst_bit: assert property (burst_enable |-> !read_config[15])
		else $error("burst enabled with page mode set");
endmodule
bind flash_bus_command_interface flash_bus_command_interface_props flash_bus_command_interface_props_i (
	.clk(clk), .rst_n(rst_n), .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
	.device_reset_n(device_reset_n), .data_oe(data_oe), .progress_pin(progress_pin),
	.eng_start(eng_start), .eng_abort(eng_abort), .read_config(read_config), .burst_enable(burst_enable));
`default_nettype wire

// File: testbench/flash_engine_model.sv
// flash_engine_model: behavioural array engine and read sources
// assumes the front end's start, suspend, resume and abort timing
`timescale 1ns/100ps
`default_nettype none
module flash_engine_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic suspend,
	input wire logic resume,
	input wire logic abort,
	input wire logic [23:0] rd_addr,
	output logic busy,
	output logic done,
	output logic [15:0] array_q,
	output logic [15:0] ident_q,
	output logic [15:0] query_q
);
	logic [7:0] cnt_r; // work cycles left
	logic held_r; // paused by suspend
	// sources vary with address so a stale select shows
	assign array_q = rd_addr[15:0] ^ 16'h5a5a;
	assign ident_q = rd_addr[15:0] | 16'h1000;
	assign query_q = rd_addr[15:0] | 16'h2000;
	// paused work reports idle, as a real engine would
	assign busy = (cnt_r != 8'h00) && !held_r;
	// work counter; only abort or rst_n wipes it, deselect never reaches here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
			held_r <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= busy && cnt_r == 8'h01;
			if (abort) begin
				cnt_r <= 8'h00;
				held_r <= 1'b0;
			end else if (start) begin
				cnt_r <= 8'h28;
			end else if (suspend) begin
				held_r <= 1'b1;
			end else if (resume) begin
				held_r <= 1'b0;
			end else if (busy) begin
				cnt_r <= cnt_r - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// File: testbench/tb_flash_bus_command_interface.sv
// tb_flash_bus_command_interface: directed bench for the command front end
// assumes the engine model as far side; host pins driven at falling edges
`timescale 1ns/100ps
`default_nettype none
module tb_flash_bus_command_interface;
	logic clk, rst_n, chip_select_n, write_strobe_n, output_enable_n, device_reset_n;
	logic [23:0] address, read_addr, eng_addr, s_addr, buf_addr_q;
	logic [15:0] data_in, data_out, array_q, ident_q, query_q, eng_data, read_config, s_data, buf_data_q;
	logic [4:0] buf_idx; // write-buffer word to read back
	logic data_oe, progress_pin, eng_start, eng_suspend, eng_resume, eng_abort, eng_busy, eng_done, burst_enable;
	logic [1:0] eng_kind, s_kind;
	logic [5:0] eng_count, s_cnt;
	int fail_count = 0, n_checks = 0, n_susp = 0, n_res = 0;
	flash_bus_command_interface flash_bus_command_interface_i (.clk(clk), .rst_n(rst_n),
		.chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
		.device_reset_n(device_reset_n), .address(address), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .progress_pin(progress_pin), .read_addr(read_addr), .array_rd_data(array_q),
		.ident_rd_data(ident_q), .query_rd_data(query_q), .eng_start(eng_start), .eng_kind(eng_kind),
		.eng_addr(eng_addr), .eng_data(eng_data), .eng_count(eng_count), .eng_suspend(eng_suspend),
		.eng_resume(eng_resume), .eng_abort(eng_abort), .eng_busy(eng_busy), .eng_done(eng_done),
		.eng_fail(1'b0), .buf_rd_idx(buf_idx), .buf_rd_addr(buf_addr_q), .buf_rd_data(buf_data_q),
		.read_config(read_config),
		.burst_enable(burst_enable));
	flash_engine_model flash_engine_model_i (.clk(clk), .rst_n(rst_n), .start(eng_start), .suspend(eng_suspend),
		.resume(eng_resume), .abort(eng_abort), .rd_addr(read_addr), .busy(eng_busy), .done(eng_done),
		.array_q(array_q), .ident_q(ident_q), .query_q(query_q));
	// free-running clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// capture each start pulse, it stands one cycle only
	always @(posedge clk) begin
		if (eng_start === 1'b1) begin
			s_kind <= eng_kind;
			s_addr <= eng_addr;
			s_cnt <= eng_count;
			s_data <= eng_data;
		end
		n_susp <= n_susp + (eng_suspend === 1'b1);
		n_res <= n_res + (eng_resume === 1'b1);
	end
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// host write: select and strobe low one cycle, output enable high
	task automatic wr(input logic [23:0] a, input logic [15:0] d);
		@(negedge clk);
		chip_select_n = 1'b0;
		write_strobe_n = 1'b0;
		address = a;
		data_in = d;
		@(negedge clk);
		write_strobe_n = 1'b1; // rising strobe latches address and data
		chip_select_n = 1'b1;
		@(negedge clk);
	endtask
	task automatic rd(input logic [23:0] a, input logic [15:0] e);
		@(negedge clk);
		chip_select_n = 1'b0;
		output_enable_n = 1'b0;
		address = a;
		repeat (3) @(negedge clk);
		chk(data_oe, 1);
		chk(data_out, e);
		chip_select_n = 1'b1;
		output_enable_n = 1'b1;
	endtask
	// bounded wait for the engine to go idle
	task automatic wait_idle;
		for (int i = 0; i < 200 && eng_busy !== 1'b0; i++) @(negedge clk);
	endtask
	task automatic t_modes;
		logic [15:0] code[4] = '{16'h0090, 16'h0098, 16'h0070, 16'h00ff};
		logic [15:0] exp[4] = '{16'h0042 | 16'h1000, 16'h0042 | 16'h2000, 16'h0080, 16'h0042 ^ 16'h5a5a};
		rd(24'h000042, 16'h0042 ^ 16'h5a5a);
		chk(read_config, 16'hffc7);
		foreach (code[i]) begin
			wr(24'h000042, code[i]);
			rd(24'h000042, exp[i]);
		end
	endtask
	task automatic t_prog;
		logic [15:0] pc[2] = '{16'h0040, 16'h0010};
		foreach (pc[i]) begin
			wr(24'h000100, pc[i]);
			wr(24'h000123, 16'hbee0);
			rd(24'h0, 16'h0000);
			chk(progress_pin, 1);
			chk(eng_abort, 0);
			chk(s_kind, 0);
			chk(s_addr, 24'h000123);
			chk(s_data, 16'hbee0);
			wait_idle;
			rd(24'h0, 16'h0080);
		end
	endtask
	task automatic t_erase_susp;
		wr(24'h020000, 16'h0020);
		wr(24'h020004, 16'h00d0);
		rd(24'h0, 16'h0000);
		chk(s_kind, 2);
		chk(s_addr, 24'h020000);
		wr(24'h0, 16'h00b0);
		rd(24'h0, 16'h00c0);
		chk(n_susp, 1);
		wr(24'h0, 16'h00d0);
		rd(24'h0, 16'h0000);
		chk(n_res, 1);
		wait_idle;
	endtask
	task automatic t_buffer;
		wr(24'h030000, 16'h00e8);
		wr(24'h030000, 16'h0002);
		wr(24'h030000, 16'h1111);
		wr(24'h030001, 16'h2222);
		wr(24'h030000, 16'h00d0);
		rd(24'h0, 16'h0000);
		chk(s_kind, 1);
		chk(s_cnt, 2);
		buf_idx = 5'h01; // second buffered word, read back one edge later
		@(negedge clk);
		chk(buf_data_q, 16'h2222);
		chk(buf_addr_q, 24'h030001);
		wait_idle;
		wr(24'h030000, 16'h00e8);
		wr(24'h030000, 16'h0000);
		wr(24'h0, 16'h0070);
		rd(24'h0, 16'h00b0);
		wr(24'h0, 16'h0050);
		rd(24'h0, 16'h0080);
	endtask
	task automatic t_config;
		wr(24'h0, 16'h00ff);
		wr(24'h007fc7, 16'h0060);
		wr(24'h007fc7, 16'h0003);
		@(negedge clk); // setting reaches the port one edge after it is taken
		chk(read_config, 16'h7fc7);
		chk(burst_enable, 1);
		wr(24'h01ffff, 16'h0060);
		wr(24'h01ffff, 16'h0003);
		@(negedge clk); // a wrongly taken setting would show by now
		chk(read_config, 16'h7fc7);
		@(negedge clk);
		chip_select_n = 1'b0; // strobe and output enable both low: read wins
		output_enable_n = 1'b0;
		write_strobe_n = 1'b0;
		data_in = 16'h0090;
		repeat (3) @(negedge clk);
		chk(data_oe, 1);
		chip_select_n = 1'b1;
		output_enable_n = 1'b1;
		write_strobe_n = 1'b1;
		rd(24'h000042, 16'h0042 ^ 16'h5a5a);
	endtask
	task automatic t_dev_reset;
		wr(24'h020000, 16'h0020);
		wr(24'h020000, 16'h00d0);
		@(negedge clk);
		chip_select_n = 1'b0;
		output_enable_n = 1'b0;
		device_reset_n = 1'b0;
		repeat (2) @(negedge clk);
		chk(eng_abort, 1);
		chk(data_oe, 0);
		device_reset_n = 1'b1;
		chip_select_n = 1'b1;
		output_enable_n = 1'b1;
		repeat (8) @(negedge clk); // recovery before the next access
		chk(read_config, 16'hffc7);
		rd(24'h000042, 16'h0042 ^ 16'h5a5a);
		wr(24'h0, 16'h0070);
		rd(24'h0, 16'h0080);
	endtask
	task automatic t_misc;
		wr(24'h000081, 16'h00c0);
		wr(24'h000081, 16'h1234); // host keeps the word inside the legal lock range
		rd(24'h0, 16'h0000);
		chk(s_kind, 3);
		wait_idle;
		wr(24'h0, 16'h00b8);
		wr(24'h0, 16'h0001);
		wr(24'h000100, 16'h0040);
		wr(24'h000100, 16'h5555);
		rd(24'h0, 16'h0000);
		chk(progress_pin, 0);
		wait_idle;
		// pulse mode: one-cycle high one edge after done
		chk(progress_pin, 0);
		@(negedge clk);
		chk(progress_pin, 1);
		@(negedge clk);
		chk(progress_pin, 0);
	endtask
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// watchdog: the whole sequence needs far fewer cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test;
	end
	// reset then scenarios in order
	initial begin
		rst_n = 1'b0;
		chip_select_n = 1'b1;
		write_strobe_n = 1'b1;
		output_enable_n = 1'b1;
		device_reset_n = 1'b1;
		address = 24'h000000;
		data_in = 16'h0000;
		buf_idx = 5'h00;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		t_modes;
		t_prog;
		t_erase_susp;
		t_buffer;
		t_config;
		t_dev_reset;
		t_misc;
		stop_test;
	end
endmodule
`default_nettype wire
